/* dv/tsf_phy_model.sv */
// Behavioural PHY: link clocks, receive driver, transmit capture
`timescale 1ns/10ps
module tsf_phy_model (
  output logic            tx_link_clk,
  output logic            rx_link_clk,
  input  wire logic [1:0] speed_mode,
  input  wire logic [7:0] gig_tx_byte_bus,
  input  wire logic       gig_tx_frame_enable,
  input  wire logic       gig_tx_error_line,
  input  wire logic [3:0] rgmii_tx_nibble,
  input  wire logic       rgmii_tx_control,
  input  wire logic [3:0] mii_tx_nibble,
  input  wire logic       mii_tx_enable,
  input  wire logic       mii_tx_error_line,
  output logic [7:0]      gig_rx_byte_bus,
  output logic            gig_rx_frame_valid,
  output logic            gig_rx_error_line,
  output logic [3:0]      rgmii_rx_nibble,
  output logic            rgmii_rx_control,
  output logic [3:0]      mii_rx_nibble,
  output logic            mii_rx_enable,
  output logic            mii_rx_error_line
);
  logic [7:0] cap_q[$];
  int         err_n = 0;
  logic [3:0] lo_n = 4'h0;
  logic       lo_c = 1'b0;
  bit         half;

  // Link clocks run between frames too, as a real PHY's do
  initial begin
    tx_link_clk = 1'b0;
    forever #62.5 tx_link_clk = ~tx_link_clk;
  end
  initial begin
    rx_link_clk = 1'b0;
    #17;
    forever #62.5 rx_link_clk = ~rx_link_clk;
  end
  initial begin
    {gig_rx_byte_bus, rgmii_rx_nibble, mii_rx_nibble} = 16'h5a3c;
    {gig_rx_frame_valid, gig_rx_error_line, rgmii_rx_control} = 3'h0;
    {mii_rx_enable, mii_rx_error_line} = 2'h0;
  end

  // Each edge sees what the block launched one edge earlier
  always @(posedge tx_link_clk) begin
    if (speed_mode == 2'b00 && gig_tx_frame_enable) begin
      cap_q.push_back(gig_tx_byte_bus);
      err_n += gig_tx_error_line;
    end
    if (speed_mode == 2'b01 && lo_c) begin
      cap_q.push_back({rgmii_tx_nibble, lo_n});
      err_n += !rgmii_tx_control;
    end
    if (speed_mode == 2'b10 && mii_tx_enable) begin
      if (half) cap_q.push_back({mii_tx_nibble, lo_n});
      lo_n = mii_tx_nibble;
      half = !half;
      err_n += mii_tx_error_line;
    end else half = 1'b0;
  end
  always @(negedge tx_link_clk) if (speed_mode == 2'b01) begin
    lo_n = rgmii_tx_nibble;
    lo_c = rgmii_tx_control;
  end

  task automatic send(input logic [7:0] b[$], input int ep);
    foreach (b[i]) begin
      if (speed_mode == 2'b00) begin
        @(negedge rx_link_clk);
        {gig_rx_frame_valid, gig_rx_byte_bus} = {1'b1, b[i]};
        gig_rx_error_line = (i == ep);
      end else if (speed_mode == 2'b10) begin
        for (int h = 0; h < 2; h++) begin
          @(negedge rx_link_clk);
          mii_rx_enable = 1'b1;
          mii_rx_nibble = h ? b[i][7:4] : b[i][3:0];
          // Even bytes flag the low nibble, odd bytes the high one
          mii_rx_error_line = (i == ep && h == i % 2);
        end
      end else begin
        // Data settles well before the clock edge
        @(negedge rx_link_clk) #31;
        {rgmii_rx_control, rgmii_rx_nibble} = {1'b1, b[i][3:0]};
        @(posedge rx_link_clk) #31;
        rgmii_rx_control = (i != ep);
        rgmii_rx_nibble = b[i][7:4];
      end
    end
    @(negedge rx_link_clk) #31;
    // Idle data lines show the inverse of their last value
    {gig_rx_frame_valid, gig_rx_error_line, rgmii_rx_control} = 3'h0;
    {mii_rx_enable, mii_rx_error_line} = 2'h0;
    gig_rx_byte_bus = ~gig_rx_byte_bus;
    rgmii_rx_nibble = ~rgmii_rx_nibble;
    mii_rx_nibble = ~mii_rx_nibble;
  endtask : send
endmodule : tsf_phy_model

/* dv/tsf_top_tb_top.sv */
// Self-checking bench for the PHY-side frame timing block
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tsf_top_tb_top;
  logic                     clk, rst, tx_link_clk, rx_link_clk;
  logic [1:0]               speed_mode;
  logic [7:0]               client_tx_data, gig_tx_byte_bus, client_rx_data;
  logic [7:0]               gig_rx_byte_bus;
  logic [3:0]               rgmii_tx_nibble, mii_tx_nibble;
  logic [3:0]               rgmii_rx_nibble, mii_rx_nibble;
  logic [15:0]              client_tx_ts_offset;
  logic [`TSF_TS_W-1:0]     egress_time;
  logic [`TSF_RX_ERR_W-1:0] client_rx_error_vec, rx_last;
  logic client_tx_valid, client_tx_start_of_packet, client_tx_end_of_packet;
  logic client_tx_frame_error, client_tx_ts_insert, client_tx_ready;
  logic gig_tx_frame_enable, gig_tx_error_line, rgmii_tx_control;
  logic mii_tx_enable, mii_tx_error_line, gig_rx_frame_valid;
  logic gig_rx_error_line, rgmii_rx_control, mii_rx_enable;
  logic mii_rx_error_line, client_rx_valid, client_rx_start_of_packet;
  logic client_rx_end_of_packet, rx_sop;
  logic [7:0] rq[$];
  int         errors = 0;
  int         compares = 0;

  tsf_top dut (
    .clk, .rst, .speed_mode, .tx_link_clk, .client_tx_data, .client_tx_valid,
    .client_tx_start_of_packet, .client_tx_end_of_packet,
    .client_tx_frame_error, .client_tx_ts_insert, .client_tx_ts_offset,
    .egress_time, .client_tx_ready, .gig_tx_byte_bus, .gig_tx_frame_enable,
    .gig_tx_error_line, .rgmii_tx_nibble, .rgmii_tx_control, .mii_tx_nibble,
    .mii_tx_enable, .mii_tx_error_line, .rx_link_clk, .gig_rx_byte_bus,
    .gig_rx_frame_valid, .gig_rx_error_line, .rgmii_rx_nibble,
    .rgmii_rx_control, .mii_rx_nibble, .mii_rx_enable, .mii_rx_error_line,
    .client_rx_data, .client_rx_valid, .client_rx_start_of_packet,
    .client_rx_end_of_packet, .client_rx_error_vec);

  tsf_phy_model phy (
    .tx_link_clk, .rx_link_clk, .speed_mode, .gig_tx_byte_bus,
    .gig_tx_frame_enable, .gig_tx_error_line, .rgmii_tx_nibble,
    .rgmii_tx_control, .mii_tx_nibble, .mii_tx_enable, .mii_tx_error_line,
    .gig_rx_byte_bus, .gig_rx_frame_valid, .gig_rx_error_line,
    .rgmii_rx_nibble, .rgmii_rx_control, .mii_rx_nibble, .mii_rx_enable,
    .mii_rx_error_line);

  always @(posedge clk) if (client_rx_valid === 1'b1) begin
    if (rq.size() == 0) rx_sop = client_rx_start_of_packet;
    rq.push_back(client_rx_data);
    if (client_rx_end_of_packet === 1'b1) rx_last = client_rx_error_vec;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic guard(input int k);
    if (k >= 3000) begin
      errors++;
      $display("[FAIL] %0t ns: wait ran out", $time);
      wrap_up();
    end
  endtask : guard

  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    speed_mode <= m;
    repeat (30) @(posedge clk);
  endtask : set_mode

  task automatic tx_frame(input logic [1:0] m, input int n, input bit e,
                          input bit ts);
    int k;
    logic [7:0] x;
    set_mode(m);
    phy.cap_q.delete();
    phy.err_n = 0;
    for (int i = 0; i < n; i++) begin
      client_tx_valid <= 1'b1;
      client_tx_data <= 8'h10 + 8'(i);
      client_tx_start_of_packet <= (i == 0);
      client_tx_end_of_packet <= (i == n - 1);
      client_tx_frame_error <= e && (i == n - 1);
      client_tx_ts_insert <= ts;
      for (k = 0; k < 3000; k++) begin
        @(posedge clk);
        if (client_tx_ready === 1'b1) break;
      end
      guard(k);
    end
    {client_tx_valid, client_tx_frame_error} <= 2'h0;
    for (k = 0; k < 3000 && phy.cap_q.size() < n; k++) @(posedge clk);
    guard(k);
    // Long enough for a stuck enable to add bytes
    repeat (40) @(posedge clk);
    check(phy.cap_q.size(), n);
    for (int i = 0; i < n; i++) begin
      x = 8'h10 + 8'(i);
      if (ts && i >= 3 && i <= 10) x = egress_time[8*(10-i) +: 8];
      check(phy.cap_q[i], x);
    end
    x = (m == 2'b10) ? 8'(phy.err_n) : 8'(phy.err_n != 0);
    check(x, e);
    check({gig_tx_frame_enable, rgmii_tx_control, mii_tx_enable}, 0);
  endtask : tx_frame

  task automatic rx_frame(input logic [1:0] m, input int n, input int ep);
    logic [7:0] b[$];
    int k;
    set_mode(m);
    rq.delete();
    rx_last = '1;
    for (int i = 0; i < n; i++) b.push_back(8'hc3 ^ 8'(i * 37));
    phy.send(b, ep);
    for (k = 0; k < 3000 && rx_last === '1; k++) @(posedge clk);
    guard(k);
    check(rq.size(), n);
    for (int i = 0; i < n; i++) check(rq[i], b[i]);
    check(rx_sop, 1'b1);
    check(rx_last, ep < 0 ? 6'h00 : 6'h01);
  endtask : rx_frame

  task automatic t_tx_formats;
    for (int m = 0; m < 3; m++) begin
      tx_frame(2'(m), 6, 1'b0, 1'b0);
      tx_frame(2'(m), 1, 1'b1, 1'b0);
      tx_frame(2'(m), 4, 1'b1, 1'b0);
    end
    $display("test tx_formats done");
  endtask : t_tx_formats

  task automatic t_timestamp;
    tx_frame(2'b00, 11, 1'b0, 1'b1);
    tx_frame(2'b01, 11, 1'b1, 1'b1);
    tx_frame(2'b10, 12, 1'b0, 1'b1);
    $display("test timestamp done");
  endtask : t_timestamp

  task automatic t_rx_formats;
    for (int m = 0; m < 3; m++) begin
      rx_frame(2'(m), 5, -1);
      rx_frame(2'(m), 3, 1);
      rx_frame(2'(m), 1, 0);
    end
    $display("test rx_formats done");
  endtask : t_rx_formats

  task automatic t_off;
    set_mode(2'b11);
    rq.delete();
    phy.send('{8'h55, 8'h66}, -1);
    repeat (40) @(posedge clk);
    check(rq.size(), 0);
    check({gig_tx_byte_bus, rgmii_tx_nibble, mii_tx_nibble}, 0);
    $display("test off done");
  endtask : t_off

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    speed_mode = 2'b00;
    client_tx_data = 8'h00;
    {client_tx_valid, client_tx_start_of_packet} = 2'h0;
    {client_tx_end_of_packet, client_tx_frame_error} = 2'h0;
    client_tx_ts_insert = 1'b0;
    client_tx_ts_offset = 16'h0003;
    egress_time = 64'h0123456789abcdef;
    rx_last = '1;
    repeat (2) @(posedge clk);
    check({client_tx_ready, gig_tx_frame_enable, mii_tx_enable}, 0);
    rst <= 1'b0;
    t_tx_formats();
    t_timestamp();
    t_rx_formats();
    t_off();
    wrap_up();
  end
endmodule : tsf_top_tb_top

/* verilog/tsf_defines.svh */
// Constants shared by the frame timing block
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH
`define TSF_TS_W       64
`define TSF_TS_BYTES   16'h0008
`define TSF_RX_ERR_W   6
`define TSF_RX_ERR_PHY 0
`define TSF_PIN_W      21
`define TSF_BYTE_RST   8'h00
`define TSF_NIB_RST    4'h0
`endif

/* verilog/tsf_pkg.sv */
// Types for the frame timing block
package tsf_pkg;
  typedef enum logic [1:0] {
    TSF_GIG   = 2'b00,
    TSF_RGMII = 2'b01,
    TSF_MII   = 2'b10,
    TSF_OFF   = 2'b11
  } tsf_mode_t;

  typedef enum logic {
    TSF_TX_IDLE = 1'b0,
    TSF_TX_SEND = 1'b1
  } tsf_tx_st_t;
endpackage : tsf_pkg

/* verilog/tsf_rx.sv */
// Receive side: PHY pins to client byte stream
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tsf_rx (
  input wire logic clk,
  input wire logic rst,
  tsf_rx_if.mp_rx  bus
);
  tsf_pkg::tsf_mode_t       mode;
  logic [2:0]               rck_r;
  logic [`TSF_PIN_W-1:0]    pin_s1_r;
  logic [`TSF_PIN_W-1:0]    pin_s2_r;
  logic                     rise;
  logic                     fall;
  logic [7:0]               g_d;
  logic                     g_dv;
  logic                     g_er;
  logic [3:0]               r_d;
  logic                     r_ctl;
  logic [3:0]               m_d;
  logic                     m_dv;
  logic                     m_er;
  logic [3:0]               lo_r;
  logic                     rg_dv_r;
  logic                     m_er_lo_r;
  logic                     nib_hi_r;
  logic                     smp;
  logic                     dv;
  logic                     er;
  logic [7:0]               byte_in;
  logic                     pend_v_r;
  logic [7:0]               pend_d_r;
  logic                     pend_sop_r;
  logic                     in_frame_r;
  logic                     frame_err_r;
  logic [7:0]               data_r;
  logic                     valid_r;
  logic                     sop_r;
  logic                     eop_r;
  logic [`TSF_RX_ERR_W-1:0] err_r;

  assign mode = tsf_pkg::tsf_mode_t'(bus.mode);

  // Clock and pins share one two-stage path so they stay aligned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rck_r    <= 3'h0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      rck_r    <= {rck_r[1:0], bus.link_clk};
      pin_s1_r <= {bus.gig_d, bus.gig_dv, bus.gig_er, bus.rg_d, bus.rg_ctl,
                   bus.mii_d, bus.mii_dv, bus.mii_er};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign rise = rck_r[1] & ~rck_r[2];
  assign fall = ~rck_r[1] & rck_r[2];
  assign {g_d, g_dv, g_er, r_d, r_ctl, m_d, m_dv, m_er} = pin_s2_r;

  always_comb begin
    smp     = 1'b0;
    dv      = 1'b0;
    er      = 1'b0;
    byte_in = `TSF_BYTE_RST;
    case (mode)
      tsf_pkg::TSF_GIG: begin
        smp     = rise;
        dv      = g_dv;
        er      = g_er;
        byte_in = g_d;
      end
      tsf_pkg::TSF_RGMII: begin
        smp     = fall;
        dv      = rg_dv_r;
        er      = r_ctl ^ rg_dv_r;
        byte_in = {r_d, lo_r};
      end
      tsf_pkg::TSF_MII: begin
        smp     = rise & (~m_dv | nib_hi_r);
        dv      = m_dv;
        er      = m_er | m_er_lo_r;
        byte_in = {m_d, lo_r};
      end
      default: smp = 1'b0;
    endcase
  end

  // Low nibble capture; an odd trailing nibble is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_r      <= `TSF_NIB_RST;
      rg_dv_r   <= 1'b0;
      m_er_lo_r <= 1'b0;
      nib_hi_r  <= 1'b0;
    end else if (rise && mode == tsf_pkg::TSF_RGMII) begin
      lo_r    <= r_d;
      rg_dv_r <= r_ctl;
    end else if (rise && mode == tsf_pkg::TSF_MII) begin
      if (m_dv && !nib_hi_r) begin
        lo_r      <= m_d;
        m_er_lo_r <= m_er;
        nib_hi_r  <= 1'b1;
      end else begin
        m_er_lo_r <= 1'b0;
        nib_hi_r  <= 1'b0;
      end
    end
  end

  // One byte held back so the last one can carry end and error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_v_r    <= 1'b0;
      pend_d_r    <= `TSF_BYTE_RST;
      pend_sop_r  <= 1'b0;
      in_frame_r  <= 1'b0;
      frame_err_r <= 1'b0;
      data_r      <= `TSF_BYTE_RST;
      valid_r     <= 1'b0;
      sop_r       <= 1'b0;
      eop_r       <= 1'b0;
      err_r       <= '0;
    end else begin
      valid_r <= 1'b0;
      // Error bit must not outlive its end byte
      err_r   <= '0;
      if (smp && dv) begin
        if (pend_v_r) begin
          data_r  <= pend_d_r;
          valid_r <= 1'b1;
          sop_r   <= pend_sop_r;
          eop_r   <= 1'b0;
          err_r   <= '0;
        end
        pend_v_r    <= 1'b1;
        pend_d_r    <= byte_in;
        pend_sop_r  <= ~in_frame_r;
        in_frame_r  <= 1'b1;
        if (er) begin
          frame_err_r <= 1'b1;
        end
      end else if (smp) begin
        if (pend_v_r) begin
          data_r  <= pend_d_r;
          valid_r <= 1'b1;
          sop_r   <= pend_sop_r;
          eop_r   <= 1'b1;
          err_r   <= '0;
          err_r[`TSF_RX_ERR_PHY] <= frame_err_r;
        end
        pend_v_r    <= 1'b0;
        in_frame_r  <= 1'b0;
        frame_err_r <= 1'b0;
      end
    end
  end

  assign bus.out_data  = data_r;
  assign bus.out_valid = valid_r;
  assign bus.out_sop   = sop_r;
  assign bus.out_eop   = eop_r;
  assign bus.out_err   = err_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rx_err_eop;
    err_r[`TSF_RX_ERR_PHY] |-> (eop_r && valid_r);
  endproperty
  a_rx_err_eop: assert property (p_rx_err_eop)
    else $error("rx error bit without end of packet");

  property p_rx_gig_err;
    (mode == tsf_pkg::TSF_GIG && smp && g_dv && g_er) |=> frame_err_r;
  endproperty
  a_rx_gig_err: assert property (p_rx_gig_err)
    else $error("gigabit receive error not recorded");

  property p_rx_rg_err;
    (mode == tsf_pkg::TSF_RGMII && fall && rg_dv_r && !r_ctl)
      |=> frame_err_r;
  endproperty
  a_rx_rg_err: assert property (p_rx_rg_err)
    else $error("reduced-pin receive error not recorded");

  property p_rx_mii_err;
    (mode == tsf_pkg::TSF_MII && smp && m_dv && m_er) |=> frame_err_r;
  endproperty
  a_rx_mii_err: assert property (p_rx_mii_err)
    else $error("nibble receive error not recorded");

  property p_rx_end;
    (valid_r && eop_r) |-> $past(smp && !dv);
  endproperty
  a_rx_end: assert property (p_rx_end)
    else $error("end of packet without valid dropping");

  c_rx_err_frame: cover property (valid_r && err_r[`TSF_RX_ERR_PHY]);
endmodule : tsf_rx

/* verilog/tsf_rx_if.sv */
// Receive pins in and client receive stream out
`timescale 1ns/10ps
interface tsf_rx_if;
  logic [1:0] mode;
  logic       link_clk;
  logic [7:0] gig_d;
  logic       gig_dv;
  logic       gig_er;
  logic [3:0] rg_d;
  logic       rg_ctl;
  logic [3:0] mii_d;
  logic       mii_dv;
  logic       mii_er;
  logic [7:0] out_data;
  logic       out_valid;
  logic       out_sop;
  logic       out_eop;
  logic [5:0] out_err;

  modport mp_top (output mode, link_clk, gig_d, gig_dv, gig_er, rg_d,
                  rg_ctl, mii_d, mii_dv, mii_er,
                  input out_data, out_valid, out_sop, out_eop, out_err);
  modport mp_rx (input mode, link_clk, gig_d, gig_dv, gig_er, rg_d,
                 rg_ctl, mii_d, mii_dv, mii_er,
                 output out_data, out_valid, out_sop, out_eop, out_err);
endinterface : tsf_rx_if

/* verilog/tsf_top.sv */
// PHY-side frame timing: client stream to GMII/RGMII/MII and back
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tsf_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [1:0]           speed_mode,
  input  wire logic                 tx_link_clk,
  input  wire logic [7:0]           client_tx_data,
  input  wire logic                 client_tx_valid,
  input  wire logic                 client_tx_start_of_packet,
  input  wire logic                 client_tx_end_of_packet,
  input  wire logic                 client_tx_frame_error,
  input  wire logic                 client_tx_ts_insert,
  input  wire logic [15:0]          client_tx_ts_offset,
  input  wire logic [`TSF_TS_W-1:0] egress_time,
  output logic                      client_tx_ready,
  output logic [7:0]                gig_tx_byte_bus,
  output logic                      gig_tx_frame_enable,
  output logic                      gig_tx_error_line,
  output logic [3:0]                rgmii_tx_nibble,
  output logic                      rgmii_tx_control,
  output logic [3:0]                mii_tx_nibble,
  output logic                      mii_tx_enable,
  output logic                      mii_tx_error_line,
  input  wire logic                 rx_link_clk,
  input  wire logic [7:0]           gig_rx_byte_bus,
  input  wire logic                 gig_rx_frame_valid,
  input  wire logic                 gig_rx_error_line,
  input  wire logic [3:0]           rgmii_rx_nibble,
  input  wire logic                 rgmii_rx_control,
  input  wire logic [3:0]           mii_rx_nibble,
  input  wire logic                 mii_rx_enable,
  input  wire logic                 mii_rx_error_line,
  output logic [7:0]                client_rx_data,
  output logic                      client_rx_valid,
  output logic                      client_rx_start_of_packet,
  output logic                      client_rx_end_of_packet,
  output logic [`TSF_RX_ERR_W-1:0]  client_rx_error_vec
);
  tsf_pkg::tsf_mode_t     mode;
  tsf_pkg::tsf_tx_st_t    st_r;
  logic [2:0]             tck_r;
  logic                   tx_rise;
  logic                   tx_fall;
  logic                   ready_r;
  logic                   take;
  logic                   hold_v_r;
  logic                   hold_v_nxt;
  logic [7:0]             hold_d_r;
  logic                   hold_sop_r;
  logic                   hold_eop_r;
  logic                   hold_err_r;
  logic                   ts_ins_r;
  logic [15:0]            ts_off_r;
  logic [`TSF_TS_W-1:0]   ts_cap_r;
  logic [`TSF_TS_W-1:0]   ts_src;
  logic [15:0]            idx_r;
  logic [15:0]            idx_ld;
  logic [15:0]            ts_rel;
  logic                   ts_hit;
  logic [7:0]             ts_byte;
  logic [7:0]             ld_byte;
  logic                   byte_edge;
  logic                   load_ok;
  logic [7:0]             cur_d_r;
  logic                   cur_eop_r;
  logic                   cur_err_r;
  logic                   nib_hi_r;
  logic                   is_gig;
  logic                   is_rg;
  logic                   is_mii;

  tsf_rx_if rxi ();

  // Speed is static configuration; 2'b11 parks every pin format
  assign mode   = tsf_pkg::tsf_mode_t'(speed_mode);
  assign is_gig = (mode == tsf_pkg::TSF_GIG);
  assign is_rg  = (mode == tsf_pkg::TSF_RGMII);
  assign is_mii = (mode == tsf_pkg::TSF_MII);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_r <= 3'h0;
    end else begin
      tck_r <= {tck_r[1:0], tx_link_clk};
    end
  end

  assign tx_rise = tck_r[1] & ~tck_r[2];
  assign tx_fall = ~tck_r[1] & tck_r[2];

  always_comb begin
    take       = client_tx_valid & ready_r;
    byte_edge  = tx_rise & (~is_mii | ~nib_hi_r);
    load_ok    = hold_v_r & ((st_r == tsf_pkg::TSF_TX_SEND) ? ~cur_eop_r
                                                             : hold_sop_r);
    hold_v_nxt = take | (hold_v_r & ~(byte_edge & load_ok));
    idx_ld     = (st_r == tsf_pkg::TSF_TX_SEND) ? idx_r + 16'h0001 : 16'h0000;
    ts_src     = (st_r == tsf_pkg::TSF_TX_SEND) ? ts_cap_r : egress_time;
    ts_rel     = idx_ld - ts_off_r;
    ts_hit     = ts_ins_r & (idx_ld >= ts_off_r) & (ts_rel < `TSF_TS_BYTES);
    ts_byte    = ts_src[{3'h7 - ts_rel[2:0], 3'h0} +: 8];
    ld_byte    = ts_hit ? ts_byte : hold_d_r;
  end

  // One-deep holding stage; two-step request inputs do not exist here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_v_r   <= 1'b0;
      hold_d_r   <= `TSF_BYTE_RST;
      hold_sop_r <= 1'b0;
      hold_eop_r <= 1'b0;
      hold_err_r <= 1'b0;
      ts_ins_r   <= 1'b0;
      ts_off_r   <= 16'h0000;
      ready_r    <= 1'b0;
    end else begin
      hold_v_r <= hold_v_nxt;
      ready_r  <= ~hold_v_nxt;
      if (take) begin
        hold_d_r   <= client_tx_data;
        hold_sop_r <= client_tx_start_of_packet;
        hold_eop_r <= client_tx_end_of_packet;
        hold_err_r <= client_tx_frame_error & client_tx_end_of_packet;
        if (client_tx_start_of_packet) begin
          ts_ins_r <= client_tx_ts_insert;
          ts_off_r <= client_tx_ts_offset;
        end
      end
    end
  end

  // Frame sequencing; a starved frame ends early, and its next byte, lacking start of packet, then stalls the holding stage until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r      <= tsf_pkg::TSF_TX_IDLE;
      cur_d_r   <= `TSF_BYTE_RST;
      cur_eop_r <= 1'b0;
      cur_err_r <= 1'b0;
      nib_hi_r  <= 1'b0;
      idx_r     <= 16'h0000;
      ts_cap_r  <= '0;
    end else if (byte_edge) begin
      if (load_ok) begin
        st_r      <= tsf_pkg::TSF_TX_SEND;
        cur_d_r   <= ld_byte;
        cur_eop_r <= hold_eop_r;
        cur_err_r <= hold_err_r;
        nib_hi_r  <= is_mii;
        idx_r     <= idx_ld;
        if (st_r == tsf_pkg::TSF_TX_IDLE) begin
          ts_cap_r <= egress_time;
        end
      end else begin
        st_r     <= tsf_pkg::TSF_TX_IDLE;
        nib_hi_r <= 1'b0;
      end
    end else if (tx_rise) begin
      nib_hi_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gig_tx_byte_bus     <= `TSF_BYTE_RST;
      gig_tx_frame_enable <= 1'b0;
      gig_tx_error_line   <= 1'b0;
    end else if (!is_gig) begin
      gig_tx_byte_bus     <= `TSF_BYTE_RST;
      gig_tx_frame_enable <= 1'b0;
      gig_tx_error_line   <= 1'b0;
    end else if (byte_edge) begin
      gig_tx_byte_bus     <= load_ok ? ld_byte : `TSF_BYTE_RST;
      gig_tx_frame_enable <= load_ok;
      gig_tx_error_line   <= load_ok & hold_eop_r & hold_err_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rgmii_tx_nibble  <= `TSF_NIB_RST;
      rgmii_tx_control <= 1'b0;
    end else if (!is_rg) begin
      rgmii_tx_nibble  <= `TSF_NIB_RST;
      rgmii_tx_control <= 1'b0;
    end else if (byte_edge) begin
      rgmii_tx_nibble  <= load_ok ? ld_byte[3:0] : `TSF_NIB_RST;
      rgmii_tx_control <= load_ok;
    end else if (tx_fall) begin
      if (st_r == tsf_pkg::TSF_TX_SEND) begin
        rgmii_tx_nibble  <= cur_d_r[7:4];
        rgmii_tx_control <= ~(cur_eop_r & cur_err_r);
      end else begin
        rgmii_tx_nibble  <= `TSF_NIB_RST;
        rgmii_tx_control <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mii_tx_nibble     <= `TSF_NIB_RST;
      mii_tx_enable     <= 1'b0;
      mii_tx_error_line <= 1'b0;
    end else if (!is_mii) begin
      mii_tx_nibble     <= `TSF_NIB_RST;
      mii_tx_enable     <= 1'b0;
      mii_tx_error_line <= 1'b0;
    end else if (byte_edge) begin
      mii_tx_nibble     <= load_ok ? ld_byte[3:0] : `TSF_NIB_RST;
      mii_tx_enable     <= load_ok;
      mii_tx_error_line <= load_ok & hold_eop_r & hold_err_r;
    end else if (tx_rise) begin
      mii_tx_nibble     <= cur_d_r[7:4];
      mii_tx_error_line <= 1'b0;
    end
  end

  assign client_tx_ready = ready_r;

  assign rxi.mode     = speed_mode;
  assign rxi.link_clk = rx_link_clk;
  assign rxi.gig_d    = gig_rx_byte_bus;
  assign rxi.gig_dv   = gig_rx_frame_valid;
  assign rxi.gig_er   = gig_rx_error_line;
  assign rxi.rg_d     = rgmii_rx_nibble;
  assign rxi.rg_ctl   = rgmii_rx_control;
  assign rxi.mii_d    = mii_rx_nibble;
  assign rxi.mii_dv   = mii_rx_enable;
  assign rxi.mii_er   = mii_rx_error_line;

  tsf_rx u_rx (
    .clk (clk),
    .rst (rst),
    .bus (rxi.mp_rx)
  );

  assign client_rx_data            = rxi.out_data;
  assign client_rx_valid           = rxi.out_valid;
  assign client_rx_start_of_packet = rxi.out_sop;
  assign client_rx_end_of_packet   = rxi.out_eop;
  assign client_rx_error_vec       = rxi.out_err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_gig_launch;
    (is_gig && $past(is_gig) && $changed(gig_tx_byte_bus)) |-> $past(tx_rise);
  endproperty
  a_gig_launch: assert property (p_gig_launch)
    else $error("gigabit byte changed off the rising edge");

  property p_gig_err;
    gig_tx_error_line |-> gig_tx_frame_enable;
  endproperty
  a_gig_err: assert property (p_gig_err)
    else $error("gigabit error outside a frame");

  property p_rg_edge;
    (is_rg && $past(is_rg) && $changed(rgmii_tx_control))
      |-> $past(tx_rise || tx_fall);
  endproperty
  a_rg_edge: assert property (p_rg_edge)
    else $error("reduced-pin control moved off a clock edge");

  property p_rg_err;
    (is_rg && tx_fall && !byte_edge && st_r == tsf_pkg::TSF_TX_SEND &&
     cur_eop_r && cur_err_r) |=> !rgmii_tx_control;
  endproperty
  a_rg_err: assert property (p_rg_err)
    else $error("reduced-pin error not shown on falling edge");

  property p_mii_err;
    (is_mii && mii_tx_error_line && tx_rise) |=> !mii_tx_error_line;
  endproperty
  a_mii_err: assert property (p_mii_err)
    else $error("nibble error line held beyond one clock");

  property p_idle;
    !$past(is_gig) |-> (!gig_tx_frame_enable && !gig_tx_error_line);
  endproperty
  a_idle: assert property (p_idle)
    else $error("gigabit enable active in another format");

  property p_ts;
    (is_gig && byte_edge && load_ok && ts_hit)
      |=> gig_tx_byte_bus == $past(ts_byte);
  endproperty
  a_ts: assert property (p_ts)
    else $error("timestamp byte not inserted");

  c_gig_err_frame: cover property (gig_tx_error_line);
  c_ts_insert: cover property (byte_edge && load_ok && ts_hit);
endmodule : tsf_top
